// >>> common/ddrc_pkg.sv
// Shared constants and types for the drive data register command block.
// Assumes a single core clock and a synchronous active-low reset.
package ddrc_pkg;

  // Command operation codes on the command port
  typedef enum logic [2:0] {
    DDRC_OP_COUNT_UP = 3'h0, // Buffered: add one
    DDRC_OP_COUNT_DOWN = 3'h1, // Buffered: subtract one
    DDRC_OP_LOAD = 3'h2, // Immediate: load or query
    DDRC_OP_COPY = 3'h3, // Buffered: copy source to destination
    DDRC_OP_DAMP = 3'h4, // Buffered: anti-resonance switch or query
    DDRC_OP_BOOT = 3'h5 // Immediate: clear faults and reload startup
  } ddrc_op_t;

  // Kind of answer on the response port
  typedef enum logic [1:0] {
    DDRC_RSP_REG = 2'h0, // Register letter = value
    DDRC_RSP_DAMP = 2'h1, // Damping switch = setting
    DDRC_RSP_ERR = 2'h2 // Value out of range or unknown operation
  } ddrc_rsp_t;

  // Default number of data registers and queue depth
  localparam int DDRC_NREG = 32;
  localparam int DDRC_QDEPTH = 4;

  // Width of a stored data word and of a short register
  localparam int DDRC_DW = 32;
  localparam int DDRC_SHORT_W = 16;

  // Value after reset and after a restart for every data register
  localparam logic [31:0] DDRC_BOOT_VALUE = 32'h0000_0000;

  // Most negative long is outside the symmetric legal range
  localparam logic [31:0] DDRC_LONG_OUT = 32'h8000_0000;

  // Damping constant not used; reset always loads the retained nv_damp_in value
  localparam logic DDRC_DAMP_RESET = 1'b0;

  // Reset values of control state
  localparam logic DDRC_EN_RESET = 1'b0;
  localparam logic DDRC_FAULT_RESET = 1'b0;

endpackage

// >>> rtl/ddrc_cmd_queue.sv
// Arrival-order queue for buffered commands, flip-flop storage.
// Assumes push is only asserted while not_full is high.
`timescale 1ns/1ps
module ddrc_cmd_queue #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic push,
  input wire logic [WIDTH-1:0] push_data,
  input wire logic pop,
  output logic [WIDTH-1:0] head_data,
  output logic not_empty_q,
  output logic not_full_q
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  // Refuse shapes the pointer logic cannot serve
  initial
  begin
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1)
      $error("ddrc_cmd_queue: DEPTH must be a power of two >= 2");
  end

  logic [WIDTH-1:0] mem_q [DEPTH]; // Entry storage
  logic [WIDTH-1:0] mem_d [DEPTH];
  logic [AW-1:0] wr_q, wr_d, rd_q, rd_d; // Pointers wrap naturally
  logic [AW:0] cnt_q, cnt_d; // Occupancy
  logic ne_d, nf_d;

  assign head_data = mem_q[rd_q];

  // Next pointers, occupancy and flags
  always_comb
  begin
    mem_d = mem_q;
    wr_d = wr_q;
    rd_d = rd_q;
    cnt_d = cnt_q;
    if (push)
    begin
      mem_d[wr_q] = push_data;
      wr_d = wr_q + 1'b1;
    end
    if (pop && not_empty_q)
      rd_d = rd_q + 1'b1;
    // Simultaneous push and pop leave the count alone
    case ({push, pop && not_empty_q})
      2'b10: cnt_d = cnt_q + 1'b1;
      2'b01: cnt_d = cnt_q - 1'b1;
      default: cnt_d = cnt_q;
    endcase
    ne_d = (cnt_d != '0);
    nf_d = (cnt_d != (AW+1)'(DEPTH));
  end

  // Registers only
  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
      not_empty_q <= 1'b0;
      not_full_q <= 1'b1;
    end
    else
    begin
      wr_q <= wr_d;
      rd_q <= rd_d;
      cnt_q <= cnt_d;
      not_empty_q <= ne_d;
      not_full_q <= nf_d;
    end
    mem_q <= mem_d;
  end

endmodule

// >>> rtl/ddrc_top.sv
// Command interpreter for a drive's data registers and restart/damping.
// Assumes a host-side parser delivers decoded commands one per valid cycle.
`timescale 1ns/1ps
// Operation
// - Count down subtracts exactly one
// - Count up adds exactly one
// - Restart clears faults, reloads startup values
// - Drive stays disabled after restart
// - Loaded value range checked as long
// - Short registers keep low sixteen bits
// - Load without value returns register contents
// - Loaded value stored raw, unscaled
// - Copy source into destination, source kept
// - Any register may be copy source
// - Damping switch one enables, zero disables
module ddrc_top #(
  parameter int NREG = ddrc_pkg::DDRC_NREG,
  parameter int QDEPTH = ddrc_pkg::DDRC_QDEPTH,
  parameter logic [31:0] SHORT_MASK = 32'h0000_ff00,
  parameter logic [31:0] RO_MASK = 32'hff00_0000
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic cmd_valid,
  input wire logic [2:0] cmd_op,
  input wire logic [$clog2(NREG)-1:0] cmd_reg_a,
  input wire logic [$clog2(NREG)-1:0] cmd_reg_b,
  input wire logic cmd_has_value,
  input wire logic [31:0] cmd_value,
  output logic cmd_ready,
  output logic rsp_valid,
  output logic [1:0] rsp_kind,
  output logic [$clog2(NREG)-1:0] rsp_idx,
  output logic [31:0] rsp_value,
  input wire logic enable_req,
  input wire logic fault_event,
  input wire logic nv_damp_in,
  output logic drive_enabled,
  output logic fault_active,
  output logic damping_on,
  output logic nv_damp_write
);

  localparam int IW = $clog2(NREG);
  localparam int QW = 3 + IW + IW + 2; // op, a, b, has_value, bit

  // Refuse register counts the index width cannot serve
  initial
  begin
    if (NREG < 2 || NREG > 32)
      $error("ddrc_top: NREG must lie in 2..32");
  end

  // Data register file and control state
  logic [31:0] reg_q [NREG];
  logic [31:0] reg_d [NREG];
  logic en_q, en_d; // Drive enable
  logic fault_q, fault_d; // Any fault latched
  logic damp_q, damp_d; // Anti-resonance setting
  logic nvw_q, nvw_d; // Pulse: setting changed, persist it
  logic rv_q, rv_d;
  logic [1:0] rk_q, rk_d;
  logic [IW-1:0] ri_q, ri_d;
  logic [31:0] rval_q, rval_d;

  // Queue of buffered commands
  logic q_push, q_pop, q_ne, q_nf;
  logic [QW-1:0] q_in, q_head;
  logic imm_go; // Immediate command accepted this cycle
  logic ex_go; // Queue head executes this cycle
  ddrc_pkg::ddrc_op_t ex_op;
  logic [IW-1:0] ex_a, ex_b;
  logic ex_hv, ex_bit;

  assign cmd_ready = q_nf;
  assign rsp_valid = rv_q;
  assign rsp_kind = rk_q;
  assign rsp_idx = ri_q;
  assign rsp_value = rval_q;
  assign drive_enabled = en_q;
  assign fault_active = fault_q;
  assign damping_on = damp_q;
  assign nv_damp_write = nvw_q;

  // Fit a long into the target: short registers keep the low word
  function automatic logic [31:0] fit_word(input logic [IW-1:0] idx,
                                           input logic [31:0] v);
    if (SHORT_MASK[idx])
      fit_word = {{16{v[15]}}, v[15:0]};
    else
      fit_word = v;
  endfunction

  // Immediate ops act at once; buffered ones go to the queue in order
  always_comb
  begin
    imm_go = cmd_valid && cmd_ready &&
             (cmd_op == 3'(ddrc_pkg::DDRC_OP_LOAD) ||
              cmd_op == 3'(ddrc_pkg::DDRC_OP_BOOT));
    q_push = cmd_valid && cmd_ready && !imm_go;
    q_in = {cmd_op, cmd_reg_a, cmd_reg_b, cmd_has_value, cmd_value[0]};
    // Immediate work owns the register file; the queue waits a cycle
    ex_go = q_ne && !imm_go;
    q_pop = ex_go;
    ex_op = ddrc_pkg::ddrc_op_t'(q_head[QW-1 -: 3]);
    ex_a = q_head[2*IW+1 -: IW];
    ex_b = q_head[IW+1 -: IW];
    ex_hv = q_head[1];
    ex_bit = q_head[0];
  end

  ddrc_cmd_queue #(
    .WIDTH(QW),
    .DEPTH(QDEPTH)
  ) u_queue (
    .core_clk(core_clk),
    .resetn(resetn),
    .push(q_push),
    .push_data(q_in),
    .pop(q_pop),
    .head_data(q_head),
    .not_empty_q(q_ne),
    .not_full_q(q_nf)
  );

  // Next state of registers, control bits and response
  always_comb
  begin
    reg_d = reg_q;
    en_d = en_q;
    // A new fault wins over a restart's clear in the same cycle
    fault_d = fault_q || fault_event;
    damp_d = damp_q;
    nvw_d = 1'b0;
    rv_d = 1'b0;
    rk_d = rk_q;
    ri_d = ri_q;
    rval_d = rval_q;
    if (enable_req)
      en_d = 1'b1;
    if (imm_go && cmd_op == 3'(ddrc_pkg::DDRC_OP_BOOT))
    begin
      // Reload every register from the startup set
      for (int i = 0; i < NREG; i++)
        reg_d[i] = ddrc_pkg::DDRC_BOOT_VALUE;
      fault_d = fault_event;
      en_d = 1'b0; // Enable request is overridden
    end
    else if (imm_go)
    begin
      ri_d = cmd_reg_a;
      rv_d = 1'b1;
      if (!cmd_has_value)
      begin
        // Query: read-only registers may be read back too
        rk_d = ddrc_pkg::DDRC_RSP_REG;
        rval_d = reg_q[cmd_reg_a];
      end
      else if (cmd_value == ddrc_pkg::DDRC_LONG_OUT)
      begin
        // Outside the symmetric long range: refuse, report
        rk_d = ddrc_pkg::DDRC_RSP_ERR;
        rval_d = cmd_value;
      end
      else
      begin
        rv_d = 1'b0; // Successful load sends nothing
        // Raw number, no scaling; read-only targets are left alone
        if (!RO_MASK[cmd_reg_a])
          reg_d[cmd_reg_a] = fit_word(cmd_reg_a, cmd_value);
      end
    end
    if (ex_go)
    begin
      case (ex_op)
        ddrc_pkg::DDRC_OP_COUNT_UP:
        begin
          if (!RO_MASK[ex_a])
            reg_d[ex_a] = fit_word(ex_a, reg_q[ex_a] + 32'h1);
        end
        ddrc_pkg::DDRC_OP_COUNT_DOWN:
        begin
          if (!RO_MASK[ex_a])
            reg_d[ex_a] = fit_word(ex_a, reg_q[ex_a] - 32'h1);
        end
        ddrc_pkg::DDRC_OP_COPY:
        begin
          // Source may be any register, read-only included
          if (!RO_MASK[ex_b])
            reg_d[ex_b] = fit_word(ex_b, reg_q[ex_a]);
        end
        ddrc_pkg::DDRC_OP_DAMP:
        begin
          if (ex_hv)
          begin
            damp_d = ex_bit;
            nvw_d = (ex_bit != damp_q); // Persist only real changes
          end
          else
          begin
            rv_d = 1'b1;
            rk_d = ddrc_pkg::DDRC_RSP_DAMP;
            rval_d = {31'h0, damp_q};
          end
        end
        default:
        begin
          // Unknown operation: refuse and report
          rv_d = 1'b1;
          rk_d = ddrc_pkg::DDRC_RSP_ERR;
          ri_d = ex_a;
          rval_d = 32'h0;
        end
      endcase
    end
  end

  // Registers only; damping setting comes back from retained storage
  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      for (int i = 0; i < NREG; i++)
        reg_q[i] <= ddrc_pkg::DDRC_BOOT_VALUE;
      en_q <= ddrc_pkg::DDRC_EN_RESET;
      fault_q <= ddrc_pkg::DDRC_FAULT_RESET;
      damp_q <= nv_damp_in; // Clocked capture of retained value
      nvw_q <= 1'b0;
      rv_q <= 1'b0;
      rk_q <= ddrc_pkg::DDRC_RSP_REG;
      ri_q <= '0;
      rval_q <= 32'h0;
    end
    else
    begin
      reg_q <= reg_d;
      en_q <= en_d;
      fault_q <= fault_d;
      damp_q <= damp_d;
      nvw_q <= nvw_d;
      rv_q <= rv_d;
      rk_q <= rk_d;
      ri_q <= ri_d;
      rval_q <= rval_d;
    end
  end

  // Checks tied to the logic above
  logic boot_go;
  logic load_go;
  assign boot_go = imm_go && cmd_op == 3'(ddrc_pkg::DDRC_OP_BOOT);
  assign load_go = imm_go && cmd_has_value &&
                   cmd_value != ddrc_pkg::DDRC_LONG_OUT &&
                   !RO_MASK[cmd_reg_a];

  sequence s_dec_long;
    ex_go && ex_op == ddrc_pkg::DDRC_OP_COUNT_DOWN &&
      !RO_MASK[ex_a] && !SHORT_MASK[ex_a];
  endsequence

  sequence s_inc_long;
    ex_go && ex_op == ddrc_pkg::DDRC_OP_COUNT_UP &&
      !RO_MASK[ex_a] && !SHORT_MASK[ex_a];
  endsequence

  a_dec_by_one: assert property (@(posedge core_clk) disable iff (!resetn)
    s_dec_long |=> reg_q[$past(ex_a)] == $past(reg_q[ex_a]) - 32'h1)
    else $error("count down did not subtract one");

  a_inc_by_one: assert property (@(posedge core_clk) disable iff (!resetn)
    s_inc_long |=> reg_q[$past(ex_a)] == $past(reg_q[ex_a]) + 32'h1)
    else $error("count up did not add one");

  a_boot_clears: assert property (@(posedge core_clk) disable iff (!resetn)
    boot_go && !fault_event |=> !fault_q && reg_q[0] == ddrc_pkg::DDRC_BOOT_VALUE)
    else $error("restart left a fault or a stale register");

  a_boot_disable: assert property (@(posedge core_clk) disable iff (!resetn)
    boot_go |=> !drive_enabled ##1 (drive_enabled -> $past(enable_req)))
    else $error("drive enabled after restart without request");

  a_load_range: assert property (@(posedge core_clk) disable iff (!resetn)
    imm_go && cmd_op == 3'(ddrc_pkg::DDRC_OP_LOAD) && cmd_has_value &&
      cmd_value == ddrc_pkg::DDRC_LONG_OUT
      |=> rsp_valid && rsp_kind == ddrc_pkg::DDRC_RSP_ERR)
    else $error("out of range load not reported");

  a_load_short: assert property (@(posedge core_clk) disable iff (!resetn)
    load_go && SHORT_MASK[cmd_reg_a]
      |=> reg_q[$past(cmd_reg_a)][15:0] == $past(cmd_value[15:0]) &&
          reg_q[$past(cmd_reg_a)][31:16] == {16{$past(cmd_value[15])}})
    else $error("short register load kept wrong bits");

  a_load_raw: assert property (@(posedge core_clk) disable iff (!resetn)
    load_go && !SHORT_MASK[cmd_reg_a]
      |=> reg_q[$past(cmd_reg_a)] == $past(cmd_value))
    else $error("long load was not stored raw");

  a_query_value: assert property (@(posedge core_clk) disable iff (!resetn)
    imm_go && cmd_op == 3'(ddrc_pkg::DDRC_OP_LOAD) && !cmd_has_value
      |=> rsp_valid && rsp_idx == $past(cmd_reg_a) &&
          rsp_value == $past(reg_q[cmd_reg_a]))
    else $error("query answer wrong");

  a_copy_keeps: assert property (@(posedge core_clk) disable iff (!resetn)
    ex_go && ex_op == ddrc_pkg::DDRC_OP_COPY && !RO_MASK[ex_b] &&
      !SHORT_MASK[ex_b] && ex_a != ex_b
      |=> reg_q[$past(ex_b)] == $past(reg_q[ex_a]) &&
          reg_q[$past(ex_a)] == $past(reg_q[ex_a]))
    else $error("copy wrong or source disturbed");

  a_damp_switch: assert property (@(posedge core_clk) disable iff (!resetn)
    ex_go && ex_op == ddrc_pkg::DDRC_OP_DAMP && ex_hv
      |=> damping_on == $past(ex_bit))
    else $error("damping switch not applied");

  a_queue_wait: assert property (@(posedge core_clk) disable iff (!resetn)
    q_ne && imm_go |=> q_ne)
    else $error("queue drained under an immediate command");

endmodule

// >>> tb/ddrc_host.sv
// Host model: presents decoded commands on the command port.
// Assumes callers run just after a rising core_clk edge.
`timescale 1ns/1ps
module ddrc_host (
  input wire logic core_clk,
  input wire logic cmd_ready,
  output logic cmd_valid,
  output logic [2:0] cmd_op,
  output logic [4:0] cmd_reg_a,
  output logic [4:0] cmd_reg_b,
  output logic cmd_has_value,
  output logic [31:0] cmd_value,
  output logic timed_out
);
  // Idle port after time zero
  initial
  begin
    cmd_valid = 1'b0;
    {cmd_op, cmd_reg_a, cmd_reg_b, cmd_has_value} = 14'h0;
    cmd_value = 32'h0;
    timed_out = 1'b0;
  end

  // Hold the command until an edge sees ready high
  // Callers write writable targets only; read-only register 24 is only queried or used as copy source
  // Callers keep values within the symmetric range, except the DDRC_LONG_OUT refusal check in t_load
  task automatic send(input logic [2:0] op, input logic [4:0] a,
    input logic [4:0] b, input logic hv, input logic [31:0] v);
    int n;
    n = 0;
    cmd_valid = 1'b1;
    cmd_op = op;
    cmd_reg_a = a;
    cmd_reg_b = b;
    cmd_has_value = hv;
    cmd_value = v;
    while (cmd_ready !== 1'b1 && n < 64)
    begin
      @(posedge core_clk);
      #1;
      n++;
    end
    if (n >= 64)
      timed_out = 1'b1;
    @(posedge core_clk);
    #1;
  endtask

  // Release: fields turn over so stale values cannot pass
  task automatic idle();
    cmd_valid = 1'b0;
    cmd_value = ~cmd_value;
    cmd_reg_a = ~cmd_reg_a;
    cmd_reg_b = ~cmd_reg_b;
  endtask

  // Raw acceleration is rev/s^2 times six
  task automatic load_accel(input logic [4:0] a, input logic [31:0] rps2);
    send(3'h2, a, 5'h0, 1'b1, rps2 * 32'h6);
  endtask
endmodule

// >>> tb/drive_data_register_commands_test.sv
// Self-checking bench for the data register command block.
// Assumes default masks: 8..15 short, 24..31 read-only.
`timescale 1ns/1ps
module drive_data_register_commands_test;
  logic core_clk, resetn, cmd_valid, cmd_has_value, cmd_ready, rsp_valid;
  logic [2:0] cmd_op;
  logic [4:0] cmd_reg_a, cmd_reg_b, rsp_idx, got_idx;
  logic [31:0] cmd_value, rsp_value, got_val;
  logic [1:0] rsp_kind, got_kind;
  logic enable_req, fault_event, nv_damp_in, drive_enabled;
  logic fault_active, damping_on, nv_damp_write, timed_out;
  int failures = 0;
  int num_checks = 0;
  int rsp_n = 0;
  int nvw_n = 0;

  ddrc_top u_dut (.core_clk(core_clk), .resetn(resetn),
    .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_reg_a(cmd_reg_a),
    .cmd_reg_b(cmd_reg_b), .cmd_has_value(cmd_has_value),
    .cmd_value(cmd_value), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid),
    .rsp_kind(rsp_kind), .rsp_idx(rsp_idx), .rsp_value(rsp_value),
    .enable_req(enable_req), .fault_event(fault_event),
    .nv_damp_in(nv_damp_in), .drive_enabled(drive_enabled),
    .fault_active(fault_active), .damping_on(damping_on),
    .nv_damp_write(nv_damp_write));

  ddrc_host u_host (.core_clk(core_clk), .cmd_ready(cmd_ready),
    .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_reg_a(cmd_reg_a),
    .cmd_reg_b(cmd_reg_b), .cmd_has_value(cmd_has_value),
    .cmd_value(cmd_value), .timed_out(timed_out));

  // Clock, 10 ns period
  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // Answers are one-cycle pulses, so latch them as they fly by
  always @(posedge core_clk)
  begin
    if (rsp_valid === 1'b1)
    begin
      rsp_n <= rsp_n + 1;
      got_kind <= rsp_kind;
      got_idx <= rsp_idx;
      got_val <= rsp_value;
    end
    if (nv_damp_write === 1'b1)
      nvw_n <= nvw_n + 1;
  end

  task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic check_bit(input logic got, input logic exp);
    check_val({31'h0, got}, {31'h0, exp});
  endtask

  // Release the port, then let n edges pass
  task automatic cyc(input int n);
    u_host.idle();
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  // Bounded wait for an answer after count n0
  task automatic wait_rsp(input int n0);
    int n;
    n = 0;
    cyc(1);
    while (rsp_n == n0 && n < 20)
    begin
      cyc(1);
      n++;
    end
    check_bit(rsp_n != n0, 1'b1);
  endtask

  task automatic load(input logic [4:0] a, input logic [31:0] v);
    u_host.send(ddrc_pkg::DDRC_OP_LOAD, a, 5'h0, 1'b1, v);
  endtask

  task automatic op(input logic [2:0] o, input logic [4:0] a,
    input logic [4:0] b);
    u_host.send(o, a, b, 1'b0, 32'h0);
  endtask

  // Query a register and compare kind, index and value
  task automatic query(input logic [4:0] a, input logic [31:0] v);
    int n0;
    n0 = rsp_n;
    op(ddrc_pkg::DDRC_OP_LOAD, a, 5'h0);
    wait_rsp(n0);
    check_val({25'h0, got_kind, got_idx}, {27'h0, a});
    check_val(got_val, v);
  endtask

  task automatic t_reset();
    check_bit(damping_on, 1'b1);
    check_bit(drive_enabled, 1'b0);
    check_bit(fault_active, 1'b0);
    check_bit(cmd_ready, 1'b1);
    check_bit(nv_damp_write, 1'b0);
  endtask

  task automatic t_load();
    int n0;
    load(5'd3, 32'h7fff_ffff);
    query(5'd3, 32'h7fff_ffff);
    n0 = rsp_n;
    load(5'd3, ddrc_pkg::DDRC_LONG_OUT);
    wait_rsp(n0);
    check_val({30'h0, got_kind}, 32'h2);
    query(5'd3, 32'h7fff_ffff);
    load(5'd8, 32'h0001_8001);
    query(5'd8, 32'hffff_8001);
    u_host.load_accel(5'd0, 32'd10);
    query(5'd0, 32'd60);
    query(5'd24, ddrc_pkg::DDRC_BOOT_VALUE);
  endtask

  task automatic t_count();
    load(5'd4, 32'd5);
    op(ddrc_pkg::DDRC_OP_COUNT_UP, 5'd4, 5'h0);
    op(ddrc_pkg::DDRC_OP_COUNT_UP, 5'd4, 5'h0);
    op(ddrc_pkg::DDRC_OP_COUNT_DOWN, 5'd4, 5'h0);
    op(ddrc_pkg::DDRC_OP_COUNT_UP, 5'd4, 5'h0);
    op(ddrc_pkg::DDRC_OP_COUNT_UP, 5'd4, 5'h0);
    cyc(8);
    query(5'd4, 32'd8);
    load(5'd6, 32'd10);
    op(ddrc_pkg::DDRC_OP_COUNT_UP, 5'd6, 5'h0);
    query(5'd6, 32'd10);
    cyc(4);
    query(5'd6, 32'd11);
    load(5'd9, 32'h7fff);
    op(ddrc_pkg::DDRC_OP_COUNT_UP, 5'd9, 5'h0);
    op(ddrc_pkg::DDRC_OP_COUNT_DOWN, 5'd10, 5'h0);
    cyc(4);
    query(5'd9, 32'hffff_8000);
    query(5'd10, 32'hffff_ffff);
  endtask

  task automatic t_copy();
    int n0;
    load(5'd1, 32'h1234_5678);
    load(5'd5, 32'h55);
    op(ddrc_pkg::DDRC_OP_COPY, 5'd1, 5'd2);
    op(ddrc_pkg::DDRC_OP_COPY, 5'd24, 5'd5);
    cyc(4);
    query(5'd2, 32'h1234_5678);
    query(5'd1, 32'h1234_5678);
    query(5'd5, ddrc_pkg::DDRC_BOOT_VALUE);
    // Undecoded operation code queues, then answers with an error
    n0 = rsp_n;
    op(3'h6, 5'd7, 5'h0);
    wait_rsp(n0);
    check_val({25'h0, got_kind, got_idx}, {25'h0, 2'h2, 5'd7});
    check_val(got_val, 32'h0);
  endtask

  // Off then on; each change pulses the retained-store strobe
  task automatic t_damp();
    int w0, n0;
    for (int s = 0; s < 2; s++)
    begin
      w0 = nvw_n;
      u_host.send(ddrc_pkg::DDRC_OP_DAMP, 5'h0, 5'h0, 1'b1, 32'(s));
      cyc(4);
      check_bit(damping_on, 1'(s));
      check_val(32'(nvw_n), 32'(w0 + 1));
      n0 = rsp_n;
      op(ddrc_pkg::DDRC_OP_DAMP, 5'h0, 5'h0);
      wait_rsp(n0);
      check_val({30'h0, got_kind}, 32'h1);
      check_val(got_val, 32'(s));
    end
  endtask

  task automatic t_boot();
    load(5'd3, 32'h99);
    enable_req = 1'b1;
    cyc(1);
    enable_req = 1'b0;
    fault_event = 1'b1;
    cyc(1);
    fault_event = 1'b0;
    cyc(1);
    check_bit(drive_enabled, 1'b1);
    check_bit(fault_active, 1'b1);
    op(ddrc_pkg::DDRC_OP_BOOT, 5'h0, 5'h0);
    check_bit(fault_active, 1'b0);
    check_bit(drive_enabled, 1'b0);
    cyc(5);
    check_bit(drive_enabled, 1'b0);
    query(5'd3, ddrc_pkg::DDRC_BOOT_VALUE);
    // A fault arriving with the restart survives it
    fault_event = 1'b1;
    op(ddrc_pkg::DDRC_OP_BOOT, 5'h0, 5'h0);
    fault_event = 1'b0;
    cyc(2);
    check_bit(fault_active, 1'b1);
    check_bit(drive_enabled, 1'b0);
  endtask

  task automatic print_verdict();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // Whole run is a little over a hundred cycles; this is far beyond it
  initial
  begin
    #500us;
    failures++;
    print_verdict();
  end

  // Reset for 16 cycles with a retained damping of one
  initial
  begin
    resetn = 1'b0;
    nv_damp_in = 1'b1;
    enable_req = 1'b0;
    fault_event = 1'b0;
    repeat (16) @(posedge core_clk);
    #1;
    resetn = 1'b1;
    t_reset();
    t_load();
    t_count();
    t_copy();
    t_damp();
    t_boot();
    check_bit(timed_out, 1'b0);
    print_verdict();
  end
endmodule
